// ### smi_map.vh
`ifndef SMI_MAP_VH
`define SMI_MAP_VH
// cycle control codes used by the address and drive logic
`define SMI_CC_W          5
`define SMI_CC_FETCH      5'h00
`define SMI_CC_BRANCH     5'h01
`define SMI_CC_DC_READ    5'h02
`define SMI_CC_IMM_READ   5'h03
`define SMI_CC_DC_WRITE   5'h05
`define SMI_CC_PC1_OUT    5'h06
`define SMI_CC_DC_OUT     5'h09
`define SMI_CC_PCL_OUT    5'h0B
`define SMI_CC_PCL_LOAD   5'h0C
`define SMI_CC_IO_READ    5'h1A
`define SMI_CC_IO_WRITE   5'h1B
`define SMI_CC_PORT_ADDR  5'h1C
// io port numbers
`define SMI_PORT_VEC_HI   8'h0C
`define SMI_PORT_VEC_LO   8'h0D
`define SMI_PORT_INT_CTL  8'h0E
`define SMI_PORT_TIMER    8'h0F
// interrupt vector bit forced by source
`define SMI_VEC_SRC_BIT   7
`define SMI_ZERO_8        8'h00
`define SMI_ZERO_16       16'h0000
`define SMI_INT_CTL_EXT   1
`endif

// ### smi_sync2.v
`timescale 1ns/10ps
// two-stage synchroniser for one asynchronous pin
module smi_sync2 (
  input  wire clk_i,
  input  wire rst_i,
  input  wire ce_i,
  input  wire async_i,
  output wire sync_o
);
  reg meta_ff;
  reg sync_ff;
  // resets high: idle level of the active-low pins it serves
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
    end else if (ce_i) begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end
  assign sync_o = sync_ff;
endmodule // smi_sync2

// ### smi_pins.v
// Behaviour
// - act only from per-cycle control code
// - data lines carry only own registers
// - address from program or data counter
// - address outputs always driven
// - write strobe low commands ram write
// - read strobe high commands ram read
// - external low bus_drive blocks counter output
// - bus_drive line rests high, pulled up
// - bus_drive low except own drive codes
// - falling external interrupt edge requests
// - no request unless priority input low
// - request low: priority low and pending
// - ports 0C/0D hold vector, read/write
// - vector bit7 forced by interrupt source
// - port 0E interrupt control, 0F timer
`timescale 1ns/10ps
`include "smi_map.vh"
module smi_pins (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  input  wire        cycle_start_i,
  input  wire        second_access_i,
  input  wire [4:0]  cycle_control_code_i,
  input  wire [7:0]  shared_byte_lines_i,
  output reg  [7:0]  shared_byte_lines_o,
  output reg         shared_byte_lines_oe_o,
  output reg  [15:0] memory_address_lines_o,
  output reg         ram_write_n_o,
  output reg         cpu_read_o,
  input  wire        bus_drive_control_i,
  output reg         bus_drive_control_o,
  output reg         bus_drive_control_oe_o,
  input  wire        external_interrupt_in_i,
  input  wire        priority_chain_in_n_i,
  input  wire        int_ack_i,
  output reg         int_req_n_o,
  output reg  [7:0]  vector_hi_o,
  output reg  [7:0]  vector_lo_o
);
  // interrupt, priority and drive-line pins pass two flops first
  wire external_interrupt_in_s;
  wire pri_n_s;
  wire bus_drv_s;
  smi_sync2 u_sync_ext (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .async_i (external_interrupt_in_i),
    .sync_o  (external_interrupt_in_s)
  );
  smi_sync2 u_sync_pri (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .async_i (priority_chain_in_n_i),
    .sync_o  (pri_n_s)
  );
  smi_sync2 u_sync_drv (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .async_i (bus_drive_control_i),
    .sync_o  (bus_drv_s)
  );

  // counters and port registers
  reg [15:0] program_counter_ff;
  reg [15:0] backup_program_counter_ff;
  reg [15:0] data_counter_ff;
  reg [7:0]  port_addr_ff;
  reg [7:0]  int_ctl_ff;
  reg [7:0]  timer_ff;
  reg [7:0]  vec_lo_sw_ff;
  reg        ext_prev_ff;
  reg        pending_ff;
  reg [15:0] nxt_addr;
  reg        nxt_wr_n;
  reg        nxt_rd;
  reg        drive_code;
  reg [7:0]  drive_byte;

  // port decode of the latched io address
  wire sel_hi  = (port_addr_ff == `SMI_PORT_VEC_HI);
  wire sel_lo  = (port_addr_ff == `SMI_PORT_VEC_LO);
  wire sel_ctl = (port_addr_ff == `SMI_PORT_INT_CTL);
  wire sel_tmr = (port_addr_ff == `SMI_PORT_TIMER);
  wire own_port = sel_hi | sel_lo | sel_ctl | sel_tmr;
  wire cc_io_wr = (cycle_control_code_i == `SMI_CC_IO_WRITE);
  wire cc_io_rd = (cycle_control_code_i == `SMI_CC_IO_READ);

  // address source, strobes and drive choice, all from the code
  always @* begin
    nxt_addr   = program_counter_ff;
    nxt_wr_n   = 1'b1;
    nxt_rd     = 1'b0;
    drive_code = 1'b0;
    drive_byte = `SMI_ZERO_8;
    case (cycle_control_code_i)
      `SMI_CC_BRANCH, `SMI_CC_IMM_READ, `SMI_CC_PCL_LOAD: begin
        nxt_rd = second_access_i;
      end
      `SMI_CC_DC_READ: begin
        nxt_addr = second_access_i ? data_counter_ff : program_counter_ff;
        nxt_rd   = second_access_i;
      end
      `SMI_CC_DC_WRITE: begin
        nxt_addr = second_access_i ? data_counter_ff : program_counter_ff;
        nxt_wr_n = ~second_access_i;
      end
      `SMI_CC_PC1_OUT: begin
        drive_code = 1'b1;
        drive_byte = backup_program_counter_ff[7:0];
      end
      `SMI_CC_DC_OUT, `SMI_CC_PCL_OUT: begin
        drive_code = 1'b1;
        drive_byte = data_counter_ff[7:0];
      end
      `SMI_CC_IO_READ: begin
        drive_code = own_port;
        if (sel_hi) begin
          drive_byte = vector_hi_o;
        end else if (sel_lo) begin
          drive_byte = vec_lo_sw_ff;
        end else if (sel_ctl) begin
          drive_byte = int_ctl_ff;
        end else begin
          drive_byte = timer_ff;
        end
      end
      default: begin
        nxt_addr = program_counter_ff;
      end
    endcase
  end

  // registered pins; address never floats
  always @(posedge clk_i) begin
    if (rst_i) begin
      memory_address_lines_o <= `SMI_ZERO_16;
      ram_write_n_o          <= 1'b1;
      cpu_read_o             <= 1'b0;
      bus_drive_control_o    <= 1'b0;
      bus_drive_control_oe_o <= 1'b1;
      shared_byte_lines_o    <= `SMI_ZERO_8;
      shared_byte_lines_oe_o <= 1'b0;
    end else if (ce_i) begin
      memory_address_lines_o <= nxt_addr;
      ram_write_n_o          <= nxt_wr_n;
      cpu_read_o             <= nxt_rd;
      // released line rests high via the pull-up outside the core
      bus_drive_control_o    <= 1'b0;
      bus_drive_control_oe_o <= ~drive_code;
      shared_byte_lines_o    <= drive_byte;
      // an outside gate clamping the line wins over our drive
      shared_byte_lines_oe_o <= drive_code & bus_drv_s;
    end
  end

  // of the counters only the program counter moves, once per fetch; data counter keeps its reset value; no ram data taken
  always @(posedge clk_i) begin
    if (rst_i) begin
      program_counter_ff        <= `SMI_ZERO_16;
      backup_program_counter_ff <= `SMI_ZERO_16;
      data_counter_ff           <= `SMI_ZERO_16;
      port_addr_ff              <= `SMI_ZERO_8;
      vector_hi_o               <= `SMI_ZERO_8;
      vector_lo_o               <= `SMI_ZERO_8;
      vec_lo_sw_ff              <= `SMI_ZERO_8;
      int_ctl_ff                <= `SMI_ZERO_8;
      timer_ff                  <= `SMI_ZERO_8;
    end else if (ce_i && cycle_start_i) begin
      if (cycle_control_code_i == `SMI_CC_FETCH) begin
        program_counter_ff <= program_counter_ff + 16'h0001;
      end else if (cycle_control_code_i == `SMI_CC_PORT_ADDR) begin
        port_addr_ff <= shared_byte_lines_i;
      end else if (cc_io_wr && sel_hi) begin
        vector_hi_o <= shared_byte_lines_i;
      end else if (cc_io_wr && sel_lo) begin
        vec_lo_sw_ff <= shared_byte_lines_i;
        // only the external source is modelled, so every write sets its source bit
        vector_lo_o  <= {1'b1, shared_byte_lines_i[`SMI_VEC_SRC_BIT-1:0]};
      end else if (cc_io_wr && sel_ctl) begin
        int_ctl_ff <= shared_byte_lines_i;
      end else if (cc_io_wr && sel_tmr) begin
        timer_ff <= shared_byte_lines_i;
      end else if (cc_io_rd) begin
        backup_program_counter_ff <= backup_program_counter_ff;
      end
    end
  end

  // falling edge latched pending; new edge beats the acknowledge
  always @(posedge clk_i) begin
    if (rst_i) begin
      ext_prev_ff <= 1'b1;
      pending_ff  <= 1'b0;
    end else if (ce_i) begin
      ext_prev_ff <= external_interrupt_in_s;
      if (ext_prev_ff && !external_interrupt_in_s && int_ctl_ff[`SMI_INT_CTL_EXT]) begin
        pending_ff <= 1'b1;
      end else if (int_ack_i) begin
        pending_ff <= 1'b0;
      end
    end
  end

  // request only with priority input low; chain has no output
  always @(posedge clk_i) begin
    if (rst_i) begin
      int_req_n_o <= 1'b1;
    end else if (ce_i) begin
      int_req_n_o <= ~(pending_ff & ~pri_n_s);
    end
  end

endmodule // smi_pins

// ### smi_pins_sva.sv
`timescale 1ns/10ps
`include "smi_map.vh"
// pin relations of smi_pins, all in the phase clock domain
module smi_pins_chk (
  input logic       clk_i,
  input logic       rst_i,
  input logic       cycle_start_i,
  input logic       second_access_i,
  input logic [4:0] cycle_control_code_i,
  input logic       ram_write_n_o,
  input logic       cpu_read_o,
  input logic       bus_drive_control_o,
  input logic       bus_drive_control_oe_o,
  input logic       bus_drive_control_i,
  input logic       shared_byte_lines_oe_o,
  input logic       priority_chain_in_n_i,
  input logic       int_req_n_o,
  input logic [7:0] vector_hi_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // five idle samples outlast the two-flop pin synchroniser
  sequence s_pri_off; priority_chain_in_n_i [*5]; endsequence
  sequence s_wr_cmd; $past(cycle_control_code_i == `SMI_CC_DC_WRITE && second_access_i); endsequence
  sequence s_io_wr; $past(cycle_start_i && cycle_control_code_i == `SMI_CC_IO_WRITE); endsequence
  sequence s_drv_code;
    $past(cycle_control_code_i == `SMI_CC_IO_READ || cycle_control_code_i == `SMI_CC_PC1_OUT ||
          cycle_control_code_i == `SMI_CC_DC_OUT || cycle_control_code_i == `SMI_CC_PCL_OUT);
  endsequence
  property p_rst; disable iff (1'h0) rst_i |=> ram_write_n_o && !cpu_read_o && bus_drive_control_oe_o && int_req_n_o; endproperty
  a_rst: assert property (p_rst) else $error("reset levels wrong");
  property p_wr; !ram_write_n_o |-> s_wr_cmd; endproperty
  a_wr: assert property (p_wr) else $error("write strobe without write code");
  property p_rd; cpu_read_o |-> $past(second_access_i) && ram_write_n_o; endproperty
  a_rd: assert property (p_rd) else $error("read strobe outside second access");
  property p_pin; bus_drive_control_o == 1'h0; endproperty
  a_pin: assert property (p_pin) else $error("drive line driven high");
  property p_data; shared_byte_lines_oe_o |-> s_drv_code; endproperty
  a_data: assert property (p_data) else $error("bytes driven outside a drive code");
  // the line reaches the drive enable through two flops and the output flop
  property p_clamp; shared_byte_lines_oe_o |-> $past(bus_drive_control_i, 3); endproperty
  a_clamp: assert property (p_clamp) else $error("bytes driven while line held low");
  property p_pri; s_pri_off |-> int_req_n_o; endproperty
  a_pri: assert property (p_pri) else $error("request with priority high");
  // priority input passes two sync flops and the request flop
  property p_req; $fell(int_req_n_o) |-> $past(!priority_chain_in_n_i, 3); endproperty
  a_req: assert property (p_req) else $error("request fell without priority");
  property p_vec; !$stable(vector_hi_o) |-> s_io_wr; endproperty
  a_vec: assert property (p_vec) else $error("vector changed without io write");
endmodule // smi_pins_chk
bind smi_pins smi_pins_chk u_chk (.clk_i, .rst_i, .cycle_start_i, .second_access_i,
  .cycle_control_code_i, .ram_write_n_o, .cpu_read_o, .bus_drive_control_o,
  .bus_drive_control_oe_o, .bus_drive_control_i, .shared_byte_lines_oe_o,
  .priority_chain_in_n_i, .int_req_n_o,
  .vector_hi_o);

// ### smi_cpu_model.sv
`timescale 1ns/10ps
// processor side: one code per machine cycle, plus the drive line pull-up
module smi_cpu_model (
  input  logic       clk_i,
  input  logic       clamp_i,
  input  logic       drv_oe_i,
  input  logic [7:0] db_i,
  input  logic       db_oe_i,
  output logic [4:0] code_o = 5'h00,
  output logic       start_o = 1'h0,
  output logic       sec_o = 1'h0,
  output logic [7:0] db_o,
  output logic       line_o
);
  logic [7:0] cpu_d = 8'h00;
  // line rests high unless the device or the outside gate sinks it
  assign line_o = !(drv_oe_i || clamp_i);
  assign db_o = db_oe_i ? db_i : cpu_d;
  // new code every cycle; nothing sits below us in the priority chain
  task automatic cyc(input logic [4:0] c, input logic [7:0] d, input logic s);
    @(posedge clk_i);
    code_o <= c;
    start_o <= 1'h1;
    sec_o <= s;
    cpu_d <= d;
  endtask
endmodule // smi_cpu_model

// ### static_memory_interface_pins_tb.sv
`timescale 1ns/10ps
`include "smi_map.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module static_memory_interface_pins_tb;
  logic        clk_i, start, sec, line, db_oe, drv, drv_oe, wr_n, rd, req_n;
  logic        rst_i = 1'h1, external_interrupt_in = 1'h1, pri_n = 1'h1, ack = 1'h0, clamp = 1'h0;
  logic [4:0]  code;
  logic [7:0]  db_in, db_out, vhi, vlo;
  logic [15:0] addr;
  int          fail_count, checks_done;
  smi_pins dut (.clk_i, .rst_i, .ce_i(1'h1), .cycle_start_i(start), .second_access_i(sec),
    .cycle_control_code_i(code), .shared_byte_lines_i(db_in), .shared_byte_lines_o(db_out),
    .shared_byte_lines_oe_o(db_oe), .memory_address_lines_o(addr), .ram_write_n_o(wr_n),
    .cpu_read_o(rd), .bus_drive_control_i(line), .bus_drive_control_o(drv),
    .bus_drive_control_oe_o(drv_oe), .external_interrupt_in_i(external_interrupt_in),
    .priority_chain_in_n_i(pri_n), .int_ack_i(ack), .int_req_n_o(req_n),
    .vector_hi_o(vhi), .vector_lo_o(vlo));
  smi_cpu_model cpu (.clk_i, .clamp_i(clamp), .drv_oe_i(drv_oe), .db_i(db_out),
    .db_oe_i(db_oe), .code_o(code), .start_o(start), .sec_o(sec), .db_o(db_in),
    .line_o(line));
  // 10 MHz phase clock
  initial begin
    clk_i = 1'h0;
    forever #50 clk_i = ~clk_i;
  end
  // look just after the edge so registered pins have settled
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // the device drive enable lags the code by one cycle, so an idle code
  // turns the bus round before the processor puts a port number on it
  task automatic io_wr(input logic [7:0] p, input logic [7:0] v);
    cpu.cyc(`SMI_CC_BRANCH, 8'h00, 1'h0);
    cpu.cyc(`SMI_CC_PORT_ADDR, p, 1'h0);
    cpu.cyc(`SMI_CC_IO_WRITE, v, 1'h0);
    step(1);
  endtask
  task automatic t_reset;
    `CHK(addr, 16'h0000)
    `CHK(line, 1'h0)
    `CHK(drv, 1'h0)
    `CHK({wr_n, rd, db_oe, req_n}, 4'h9)
  endtask
  // program counter steps once per fetch cycle; data counter rests at zero
  task automatic t_addr;
    cpu.cyc(`SMI_CC_FETCH, 8'h00, 1'h0);
    step(2);
    `CHK(addr, 16'h0001)
    cpu.cyc(`SMI_CC_DC_READ, 8'h00, 1'h1);
    step(1);
    `CHK(addr, 16'h0000)
    cpu.cyc(`SMI_CC_DC_READ, 8'h00, 1'h0);
    step(1);
    `CHK(addr, 16'h0003)
  endtask
  task automatic t_strobe;
    cpu.cyc(`SMI_CC_DC_WRITE, 8'h3c, 1'h1);
    step(1);
    `CHK({wr_n, rd}, 2'h0)
    cpu.cyc(`SMI_CC_IMM_READ, 8'h3c, 1'h1);
    step(1);
    `CHK({wr_n, rd}, 2'h3)
    cpu.cyc(`SMI_CC_IMM_READ, 8'h3c, 1'h0);
    step(1);
    `CHK(rd, 1'h0)
  endtask
  // a foreign port write last: it must leave both vector bytes alone
  task automatic t_ports;
    io_wr(`SMI_PORT_VEC_HI, 8'h55);
    io_wr(`SMI_PORT_VEC_LO, 8'h23);
    io_wr(8'h20, 8'hff);
    `CHK(vhi, 8'h55)
    `CHK(vlo, 8'ha3)
  endtask
  // the drive line passes a synchroniser, so allow a few cycles
  task automatic t_read(input logic c, input logic e);
    @(posedge clk_i) clamp <= c;
    cpu.cyc(`SMI_CC_BRANCH, 8'h00, 1'h0);
    cpu.cyc(`SMI_CC_PORT_ADDR, `SMI_PORT_VEC_HI, 1'h0);
    cpu.cyc(`SMI_CC_IO_READ, 8'h00, 1'h0);
    step(4);
    `CHK(db_oe, e)
    `CHK(line, e)
    if (e) `CHK(db_out, 8'h55)
  endtask
  task automatic t_int;
    io_wr(`SMI_PORT_INT_CTL, 8'h02);
    @(posedge clk_i) external_interrupt_in <= 1'h0;
    step(8);
    `CHK(req_n, 1'h1)
    @(posedge clk_i) pri_n <= 1'h0;
    step(8);
    `CHK(req_n, 1'h0)
    @(posedge clk_i) ack <= 1'h1;
    @(posedge clk_i) ack <= 1'h0;
    step(8);
    `CHK(req_n, 1'h1)
    @(posedge clk_i) external_interrupt_in <= 1'h1;
    step(8);
    `CHK(req_n, 1'h1)
    @(posedge clk_i) external_interrupt_in <= 1'h0;
    step(8);
    `CHK(req_n, 1'h0)
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // traffic needs about 95 cycles; 1000 cycles means a hang
  initial begin
    #100000;
    fail_count++;
    tally_and_finish;
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    #1;
    t_reset;
    t_addr;
    t_strobe;
    t_ports;
    t_read(1'h1, 1'h0);
    t_read(1'h0, 1'h1);
    t_int;
    tally_and_finish;
  end
endmodule // static_memory_interface_pins_tb
